//--- eam_modifier.sv
/*
  effective address modifier: register, register-then-indirect and
  indirect-then-register chains, plus direct operands, with an axi4-lite
  status and control port.
  assumes the memory port holds mem_rdata valid with mem_ack for one cycle,
  and that register inputs are stable while a chain runs.
*/
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "eam_consts.svh"
module eam_modifier (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request from instruction decode
  input wire logic start,
  output logic start_ready,
  input wire eam_pkg::eam_word_t instr_word,
  // processor registers
  input wire eam_pkg::eam_half_t index_registers [8],
  input wire eam_pkg::eam_word_t acc_word,
  input wire eam_pkg::eam_word_t second_acc_word,
  input wire eam_pkg::eam_half_t program_counter_index,
  // result to execute
  output logic done,
  output eam_pkg::eam_half_t eff_addr,
  output eam_pkg::eam_word_t direct_operand,
  output logic direct_valid,
  output logic tally_unsupported,
  // memory port for indirect words
  output logic mem_req,
  output eam_pkg::eam_half_t mem_addr,
  input wire logic mem_ack,
  input wire eam_pkg::eam_word_t mem_rdata,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import eam_pkg::*;

  eam_state_t state_reg; // chain sequencer
  eam_word_t cur_reg; // word under decode: instruction or indirect
  eam_half_t saved_reg; // safe-stored register for the final index step
  logic deref_mode_reg; // inside a deref-then-index chain
  logic [1:0] ctrl_reg; // enable and counter clear
  logic [15:0] fetch_cnt_reg; // indirect fetches of the last chain
  logic [3:0] aw_addr_reg; // latched write address
  logic aw_have_reg; // write address taken
  logic [31:0] w_data_reg; // latched write data
  logic [3:0] w_strb_reg; // latched strobes
  logic w_have_reg; // write data taken

  eam_half_t y_field; // address field of current word
  logic [1:0] modifier_kind_bits; // kind subfield
  logic [3:0] designator_bits; // designator subfield
  eam_half_t sel_value; // selected register half
  eam_half_t sum_addr; // field plus selected half
  eam_half_t saved_sum; // field plus saved register
  logic is_direct; // direct operand code
  logic is_indirect; // word asks for an indirect fetch

  assign y_field = cur_reg[`EAM_ADDR_HI:`EAM_ADDR_LO];
  assign modifier_kind_bits = cur_reg[`EAM_KIND_HI:`EAM_KIND_LO];
  assign designator_bits = cur_reg[`EAM_DES_HI:`EAM_DES_LO];
  // either kind bit sets is_indirect; the chain goes on for every indirect kind but tally
  assign is_indirect = |modifier_kind_bits;
  // tally words would loop here, so outside a deref chain they are finished as unsupported
  assign saved_sum = eam_half_t'(y_field + saved_reg);

  // one shared selector serves both the instruction and every indirect word
  eam_reg_select u_sel (
    .addr_field(y_field),
    .designator_bits(designator_bits),
    .index_registers(index_registers),
    .acc_word(acc_word),
    .second_acc_word(second_acc_word),
    .program_counter_index(program_counter_index),
    .sel_value(sel_value),
    .sum_addr(sum_addr),
    .is_direct(is_direct)
  );

  // new requests only while idle and enabled
  assign start_ready = (state_reg == EAM_IDLE) && ctrl_reg[`EAM_CTRL_ENABLE];

  // chain sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= EAM_IDLE;
    end else begin
      case (state_reg)
        EAM_IDLE: begin
          if (start && start_ready) begin
            state_reg <= EAM_RUN;
          end
        end
        EAM_RUN: begin
          if (is_indirect && !(modifier_kind_bits == `EAM_KIND_IT)) begin
            state_reg <= EAM_FETCH;
          end else begin
            state_reg <= EAM_DONE;
          end
        end
        EAM_FETCH: begin
          if (mem_ack) begin
            state_reg <= EAM_RUN; // decode the fetched word
          end
        end
        EAM_DONE: state_reg <= EAM_IDLE;
        default: state_reg <= EAM_IDLE;
      endcase
    end
  end

  // current word: the instruction first, then each fetched indirect word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_reg <= '0;
    end else if (state_reg == EAM_IDLE && start && start_ready) begin
      cur_reg <= instr_word;
    end else if (state_reg == EAM_FETCH && mem_ack) begin
      cur_reg <= mem_rdata;
    end
  end

  // memory request and its address, held until acknowledged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req <= 1'b0;
      mem_addr <= '0;
    end else if (state_reg == EAM_RUN && modifier_kind_bits == `EAM_KIND_RI) begin
      // index first, then fetch from the sum; none code fetches field
      mem_req <= 1'b1;
      mem_addr <= sum_addr;
    end else if (state_reg == EAM_RUN && modifier_kind_bits == `EAM_KIND_IR) begin
      // fetch from the unmodified field
      mem_req <= 1'b1;
      mem_addr <= y_field;
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // safe-stored register for deref-then-index chains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_reg <= '0;
      deref_mode_reg <= 1'b0;
    end else if (state_reg == EAM_IDLE) begin
      saved_reg <= '0;
      deref_mode_reg <= 1'b0;
    end else if (state_reg == EAM_RUN && modifier_kind_bits == `EAM_KIND_IR) begin
      // each new one replaces the last; none code saves zero
      saved_reg <= sel_value;
      deref_mode_reg <= 1'b1;
    end
    // index-then-deref words leave the saved value alone
  end

  // final result, registered, with a one-cycle done pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      eff_addr <= '0;
      direct_operand <= '0;
      direct_valid <= 1'b0;
      tally_unsupported <= 1'b0;
    end else if (state_reg == EAM_RUN && !(is_indirect && !(modifier_kind_bits ==
        `EAM_KIND_IT))) begin
      done <= 1'b1;
      direct_valid <= 1'b0;
      direct_operand <= '0;
      tally_unsupported <= 1'b0;
      if (deref_mode_reg) begin
        // register or tally word closes a deref-then-index chain
        eff_addr <= saved_sum;
      end else if (modifier_kind_bits == `EAM_KIND_IT) begin
        // tally variations are not built; report and pass the field
        eff_addr <= y_field;
        tally_unsupported <= 1'b1;
      end else if (is_direct) begin
        // software keeps direct codes out of index-then-deref
        eff_addr <= y_field;
        direct_valid <= 1'b1;
        if (designator_bits == `EAM_DES_DU) begin
          direct_operand <= {y_field, 18'h00000};
        end else begin
          direct_operand <= {18'h00000, y_field};
        end
      end else begin
        // plain register step, also ends index-then-deref chains
        eff_addr <= sum_addr;
      end
    end else begin
      done <= 1'b0;
    end
  end

  // count indirect fetches of the running chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_cnt_reg <= '0;
    end else if (state_reg == EAM_IDLE && start && start_ready) begin
      fetch_cnt_reg <= '0;
    end else if (state_reg == EAM_FETCH && mem_ack) begin
      fetch_cnt_reg <= fetch_cnt_reg + 16'h0001;
    end else if (ctrl_reg[`EAM_CTRL_CLRCNT]) begin
      fetch_cnt_reg <= '0;
    end
  end

  // axi write side: address and data may arrive in either order
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (aw_have_reg && w_have_reg) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // control register; only lane 0 carries bits, clear bit self-clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `EAM_CTRL_RESET;
    end else if (aw_have_reg && w_have_reg && aw_addr_reg == `EAM_OFF_CTRL &&
        w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[1:0];
    end else begin
      ctrl_reg[`EAM_CTRL_CLRCNT] <= 1'b0;
    end
  end

  // write response: okay for control and read-only words, error elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EAM_RESP_OKAY;
    end else if (aw_have_reg && w_have_reg) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_reg[1:0] == 2'h0) ? `EAM_RESP_OKAY : `EAM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read side: one read at a time, answered the cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `EAM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EAM_RESP_OKAY;
      case (s_axi_araddr)
        `EAM_OFF_CTRL: s_axi_rdata <= {30'h00000000, ctrl_reg};
        `EAM_OFF_STATUS: s_axi_rdata <= {28'h0000000, tally_unsupported,
            deref_mode_reg, mem_req, !(state_reg == EAM_IDLE)};
        `EAM_OFF_LAST_EA: s_axi_rdata <= {14'h0000, eff_addr};
        `EAM_OFF_FETCHES: s_axi_rdata <= {16'h0000, fetch_cnt_reg};
        default: begin
          // unaligned or unmapped word
          s_axi_rdata <= '0;
          s_axi_rresp <= `EAM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- eam_consts.svh
/*
  constant definitions for the effective address modifier.
  assumes 36-bit words with bit 0 as the most significant bit.
*/
`ifndef EAM_CONSTS_SVH
`define EAM_CONSTS_SVH

// word fields, verilog bit numbering (word bit 0 is verilog bit 35)
`define EAM_ADDR_HI 35
`define EAM_ADDR_LO 18
// lower half of a register word
`define EAM_LOW_HI 17
`define EAM_LOW_LO 0
`define EAM_KIND_HI 5
`define EAM_KIND_LO 4
`define EAM_DES_HI 3
`define EAM_DES_LO 0

// modifier kinds
`define EAM_KIND_REG 2'h0
`define EAM_KIND_RI 2'h1
`define EAM_KIND_IT 2'h2
`define EAM_KIND_IR 2'h3

// designator codes
`define EAM_DES_NONE 4'h0
`define EAM_DES_AU 4'h1
`define EAM_DES_QU 4'h2
`define EAM_DES_DU 4'h3
`define EAM_DES_IC 4'h4
`define EAM_DES_AL 4'h5
`define EAM_DES_QL 4'h6
`define EAM_DES_DL 4'h7
`define EAM_DES_XBIT 3

// register map, byte addresses
`define EAM_OFF_CTRL 4'h0
`define EAM_OFF_STATUS 4'h4
`define EAM_OFF_LAST_EA 4'h8
`define EAM_OFF_FETCHES 4'hC
`define EAM_CTRL_RESET 2'h1
`define EAM_CTRL_ENABLE 0
`define EAM_CTRL_CLRCNT 1

// axi responses
`define EAM_RESP_OKAY 2'h0
`define EAM_RESP_SLVERR 2'h2

`endif

//--- eam_pkg.sv
/*
  types shared by the effective address modifier files.
  assumes eam_consts.svh carries the numeric constants.
*/
package eam_pkg;
  typedef logic [17:0] eam_half_t;
  typedef logic [35:0] eam_word_t;
  typedef enum logic [3:0] {
    EAM_IDLE  = 4'h1,
    EAM_RUN   = 4'h2,
    EAM_FETCH = 4'h4,
    EAM_DONE  = 4'h8
  } eam_state_t;
endpackage

//--- eam_reg_select.sv
/*
  register selection and address sum for one designator code.
  assumes register contents arrive stable from the processor.
*/
`timescale 1ns/1ps
`include "eam_consts.svh"
module eam_reg_select (
  // word under decode
  input wire eam_pkg::eam_half_t addr_field,
  input wire logic [3:0] designator_bits,
  // processor registers
  input wire eam_pkg::eam_half_t index_registers [8],
  input wire eam_pkg::eam_word_t acc_word,
  input wire eam_pkg::eam_word_t second_acc_word,
  input wire eam_pkg::eam_half_t program_counter_index,
  // results
  output eam_pkg::eam_half_t sel_value,
  output eam_pkg::eam_half_t sum_addr,
  output logic is_direct
);
  import eam_pkg::*;

  // pick the register half named by the designator
  always_comb begin
    is_direct = 1'b0;
    if (designator_bits[`EAM_DES_XBIT]) begin
      // index registers numbered in code order
      sel_value = index_registers[designator_bits[2:0]];
    end else begin
      case (designator_bits)
        `EAM_DES_AU: sel_value = acc_word[`EAM_ADDR_HI:`EAM_ADDR_LO];
        `EAM_DES_AL: sel_value = acc_word[`EAM_LOW_HI:`EAM_LOW_LO];
        `EAM_DES_QU: sel_value = second_acc_word[`EAM_ADDR_HI:`EAM_ADDR_LO];
        `EAM_DES_QL: sel_value = second_acc_word[`EAM_LOW_HI:`EAM_LOW_LO];
        `EAM_DES_IC: sel_value = program_counter_index;
        `EAM_DES_DU, `EAM_DES_DL: begin
          // direct operands add nothing; the caller builds the operand
          sel_value = '0;
          is_direct = 1'b1;
        end
        default: sel_value = '0; // no modification adds zero
      endcase
    end
  end

  // carry out of the top address bit is dropped on purpose
  assign sum_addr = eam_half_t'(addr_field + sel_value);
endmodule

//--- eam_modifier_asserts.sv
/*
  concurrent checks on the effective address modifier ports.
  assumes register inputs stay stable while a chain runs.
*/
`timescale 1ns/1ps
module eam_modifier_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // decode request and registers
  input wire logic start,
  input wire logic start_ready,
  input wire eam_pkg::eam_word_t instr_word,
  input wire eam_pkg::eam_half_t index_registers [8],
  input wire eam_pkg::eam_word_t acc_word,
  input wire eam_pkg::eam_word_t second_acc_word,
  input wire eam_pkg::eam_half_t program_counter_index,
  // results
  input wire logic done,
  input wire eam_pkg::eam_half_t eff_addr,
  input wire eam_pkg::eam_word_t direct_operand,
  input wire logic direct_valid,
  // memory port
  input wire logic mem_req,
  input wire eam_pkg::eam_half_t mem_addr,
  input wire logic mem_ack,
  input wire eam_pkg::eam_word_t mem_rdata
);
  import eam_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take; // request accepted this edge
  logic dir; // instruction carries a direct code
  logic [1:0] kind; // instruction modifier kind
  logic got; // indirect word arrives this edge
  logic in_ir_reg; // chain runs in deref-then-index mode
  eam_half_t saved_reg, exp_reg, y_reg, fexp_reg, fsum_reg, nxt_reg;
  assign take = start && start_ready;
  assign kind = instr_word[5:4];
  assign dir = !instr_word[3] && instr_word[1:0] == 2'h3;
  assign got = mem_req && mem_ack;
  // register picked by a designator, zero for none and direct codes
  function automatic eam_half_t sel(input logic [3:0] d);
    case (d)
      4'h1: return acc_word[35:18];
      4'h2: return second_acc_word[35:18];
      4'h4: return program_counter_index;
      4'h5: return acc_word[17:0];
      4'h6: return second_acc_word[17:0];
      default: return d[3] ? index_registers[d[2:0]] : 18'h0;
    endcase
  endfunction
  // mode and safe-stored value follow the chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_ir_reg <= 1'b0;
      saved_reg <= 18'h0;
    end else if (take) begin
      in_ir_reg <= kind == 2'h3;
      saved_reg <= sel(instr_word[3:0]);
    end else if (got && mem_rdata[5:4] == 2'h3) begin
      in_ir_reg <= 1'b1;
      saved_reg <= sel(mem_rdata[3:0]);
    end
  end
  // expected sums, 18-bit so the carry is lost as in the block
  always_ff @(posedge aclk) begin
    if (take) begin
      exp_reg <= instr_word[35:18] + sel(instr_word[3:0]);
      y_reg <= instr_word[35:18];
    end
    if (got) begin
      fexp_reg <= mem_rdata[35:18] + sel(mem_rdata[3:0]);
      fsum_reg <= mem_rdata[35:18] + saved_reg;
      nxt_reg <= (mem_rdata[5:4] == 2'h3) ? mem_rdata[35:18]
        : mem_rdata[35:18] + sel(mem_rdata[3:0]);
    end
  end
  plain_reg_ea_a: assert property (
    take && kind == 2'h0 && !dir |-> ##2 done && eff_addr == exp_reg)
    else $error("plain register address wrong");
  direct_upper_a: assert property (
    take && kind == 2'h0 && instr_word[3:0] == 4'h3 |-> ##2 done && direct_valid && !mem_req
    && direct_operand == {y_reg, 18'h0}) else $error("direct upper operand wrong");
  direct_lower_a: assert property (
    take && kind == 2'h0 && instr_word[3:0] == 4'h7 |-> ##2 done && direct_valid && !mem_req
    && direct_operand == {18'h0, y_reg}) else $error("direct lower operand wrong");
  ri_fetch_a: assert property (
    take && kind == 2'h1 |-> ##2 mem_req && mem_addr == exp_reg)
    else $error("indexed fetch address wrong");
  ir_fetch_a: assert property (
    take && kind == 2'h3 |-> ##2 mem_req && mem_addr == y_reg)
    else $error("deref fetch address wrong");
  chain_on_a: assert property (
    got && mem_rdata[4] |-> ##2 mem_req && !done && mem_addr == nxt_reg)
    else $error("chain did not continue");
  ri_end_a: assert property (
    got && mem_rdata[5:4] == 2'h0 && !in_ir_reg && !(!mem_rdata[3] && mem_rdata[1:0] == 2'h3)
    |-> ##2 done && eff_addr == fexp_reg) else $error("indexed chain end wrong");
  ir_end_a: assert property (
    got && mem_rdata[5:4] == 2'h0 && in_ir_reg |-> ##2 done && eff_addr == fsum_reg)
    else $error("deref chain end wrong");
  cover property (take && dir);
  cover property (got && mem_rdata[4]);
  cover property (got && mem_rdata[5:4] == 2'h0 && in_ir_reg);
endmodule
bind eam_modifier eam_modifier_asserts i_chk (.aclk, .aresetn, .start, .start_ready, .instr_word,
  .index_registers, .acc_word, .second_acc_word, .program_counter_index, .done, .eff_addr,
  .direct_operand, .direct_valid, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

//--- eam_mem_model.sv
/*
  memory port model answering indirect word fetches.
  assumes the bench fills mem and sets the answer delay.
*/
`timescale 1ns/1ps
module eam_mem_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // memory port
  input wire logic mem_req,
  input wire eam_pkg::eam_half_t mem_addr,
  output logic mem_ack,
  output eam_pkg::eam_word_t mem_rdata,
  // extra wait cycles before the answer
  input wire logic [3:0] lat
);
  import eam_pkg::*;
  eam_word_t mem [eam_half_t]; // indirect words, empty places read zero
  logic [3:0] wait_reg; // cycles spent on this request
  // one pulse per request; outside it the data lines keep flipping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_reg <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 36'h0;
    end else if (!mem_req || mem_ack) begin
      wait_reg <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_reg >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 36'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- effective_address_modifier_test.sv
/*
  self-checking bench for the effective address modifier.
  assumes the memory model stands on the fetch port.
*/
`timescale 1ns/1ps
module effective_address_modifier_test;
  import eam_pkg::*;
  logic aclk, aresetn, start, start_ready, done, direct_valid, tally_unsupported;
  logic mem_req, mem_ack, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, lat;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  eam_word_t instr_word, acc_word, second_acc_word, direct_operand, mem_rdata;
  eam_half_t index_registers [8];
  eam_half_t program_counter_index, eff_addr, mem_addr, exp_h;
  int fails, samples_checked;
  eam_modifier i_dut (.aclk, .aresetn, .start, .start_ready, .instr_word, .index_registers,
    .acc_word, .second_acc_word, .program_counter_index, .done, .eff_addr, .direct_operand,
    .direct_valid, .tally_unsupported, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  eam_mem_model i_mem (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .lat);
  always #2.5 aclk = ~aclk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo;
    fails++;
    report_and_stop();
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic eam_word_t mk(input eam_half_t y, input logic [1:0] k, input logic [3:0] d);
    return {y, 12'h0, k, d};
  endfunction
  // bench copy of the register choice by designator
  function automatic eam_half_t tsel(input logic [3:0] d);
    case (d)
      4'h1: return acc_word[35:18];
      4'h2: return second_acc_word[35:18];
      4'h4: return program_counter_index;
      4'h5: return acc_word[17:0];
      4'h6: return second_acc_word[17:0];
      default: return d[3] ? index_registers[d[2:0]] : 18'h0;
    endcase
  endfunction
  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    if (n >= 50) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    if (n >= 50) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one decode request, returns at the edge that sees done
  task automatic go(input eam_word_t w);
    int n;
    n = 0;
    @(posedge aclk);
    instr_word <= w;
    start <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!start_ready && n < 20);
    start <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (done !== 1'b1 && n < 200);
    if (n >= 200) tmo();
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {start, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lat} = '0;
    s_axi_wstrb = 4'hF;
    instr_word = 36'h0;
    acc_word = {18'h20000, 18'h00300};
    second_acc_word = {18'h04000, 18'h00050};
    program_counter_index = 18'h3FFF0; // wraps past the top with a small field
    for (int i = 0; i < 8; i++) index_registers[i] = {3'(i), 15'h0105};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(4'h0, rd, rr);
    check(rd, 32'h1);
    for (int d = 0; d < 16; d++) begin
      exp_h = eam_half_t'(18'h20 + tsel(4'(d)));
      go(mk(18'h00020, 2'h0, 4'(d)));
      if (d == 3) check(direct_operand, {18'h00020, 18'h0});
      else if (d == 7) check(direct_operand, {18'h0, 18'h00020});
      else check(eff_addr, exp_h);
      check(direct_valid, d == 3 || d == 7);
    end
    // indexed chain through a bare indirect word; direct codes kept out
    i_mem.mem[18'h20010] = mk(18'h00100, 2'h1, 4'h0);
    i_mem.mem[18'h00100] = mk(18'h00050, 2'h0, 4'h9);
    go(mk(18'h00010, 2'h1, 4'h1));
    check(eff_addr, eam_half_t'(18'h50 + index_registers[1]));
    axi_read(4'hC, rd, rr);
    check(rd, 32'h2);
    // deref chain, replaced saved value, indexed hop, slow memory
    lat <= 4'h3;
    i_mem.mem[18'h00300] = mk(18'h00310, 2'h3, 4'hA);
    i_mem.mem[18'h00310] = mk(18'h00020, 2'h1, 4'hC);
    i_mem.mem[18'h20125] = mk(18'h00040, 2'h0, 4'h5);
    go(mk(18'h00300, 2'h3, 4'h8));
    check(eff_addr, eam_half_t'(18'h40 + index_registers[2]));
    lat <= 4'h0;
    i_mem.mem[18'h00400] = mk(18'h00044, 2'h0, 4'h1);
    go(mk(18'h00400, 2'h3, 4'h0));
    check(eff_addr, 18'h00044);
    axi_read(4'h8, rd, rr);
    check(rd, 32'h44);
    // a tally word is not plain register modification; outside a deref chain it is reported
    go(mk(18'h00060, 2'h2, 4'h9));
    check(eff_addr, 18'h00060);
    check(tally_unsupported, 1'b1);
    axi_read(4'h4, rd, rr);
    check(rd, 32'h8);
    // tally word closing a deref chain adds the saved register
    i_mem.mem[18'h00500] = mk(18'h00030, 2'h2, 4'h1);
    go(mk(18'h00500, 2'h3, 4'h9));
    check(eff_addr, eam_half_t'(18'h30 + index_registers[1]));
    check(tally_unsupported, 1'b0);
    axi_read(4'hC, rd, rr);
    check(rd, 32'h1);
    axi_read(4'h2, rd, rr);
    check(rr, 2'h2);
    axi_write(4'h4, 32'h0, rr);
    check(rr, 2'h0);
    axi_write(4'h0, 32'h0, rr);
    @(posedge aclk);
    check(start_ready, 1'b0);
    // enable again and clear the fetch counter in one write
    axi_write(4'h0, 32'h3, rr);
    @(posedge aclk);
    check(start_ready, 1'b1);
    axi_read(4'hC, rd, rr);
    check(rd, 32'h0);
    axi_read(4'h0, rd, rr);
    check(rd, 32'h1);
    report_and_stop();
  end
endmodule
